// file: dv/dw_host.sv
`timescale 1ns/10ps
module dw_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  input wire logic rdy_i,
  input wire logic rdy_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  // serial out is open drain with a pull-up
  wire sdo_line = sdo_oe_i ? sdo_i : 1'b1;
  // ready/busy likewise pulled up when released
  wire rdy_line = rdy_oe_i ? rdy_i : 1'b1;

  // idle bus: deselected, clock low
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // one frame msb first, 80 ns serial clock, clock stands still outside it
  task automatic frame(input logic [23:0] cmd, output logic [23:0] resp);
    cs_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    for (int i = 23; i >= 0; i--)
    begin
      sdi_o <= cmd[i];
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b1;
      resp[i] = sdo_line;
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (10) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= !cmd[0]; // no stale data once deselected
  endtask

  // hold off until ready is released
  task automatic wait_ready;
    while (!rdy_line)
      @(posedge clk_i);
  endtask
endmodule // dw_host

// file: dv/dw_wiper_ctrl_chk.sv
`timescale 1ns/10ps
`include "dw_consts.svh"
module dw_wiper_ctrl_chk
  import dw_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdo_oe_o,
  input wire logic rdy_oe_o,
  input wire logic standby_o,
  input wire logic awake_o,
  input wire dw_wiper_t [1:0] wiper_o
);
  logic [8:0] busy_len_q;

  // length of the running busy stretch
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      busy_len_q <= 9'h000;
    else
      busy_len_q <= rdy_oe_o ? busy_len_q + 9'h001 : 9'h000;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // select is synced, so allow a few cycles to settle
  sequence deselected;
    cs_n_i [*4];
  endsequence
  sequence selected;
    !cs_n_i [*4];
  endsequence

  a_sdo_release: assert property (deselected |-> !sdo_oe_o)
    else $error("serial out driven while deselected");
  a_sdo_fall_edge: assert property ($changed(sdo_oe_o) |-> !sclk_i)
    else $error("serial out moved while serial clock high");
  a_select_active: assert property (selected |-> !standby_o && !rdy_oe_o)
    else $error("selected but standby or busy");
  a_busy_standby: assert property (rdy_oe_o |-> !standby_o)
    else $error("standby during access cycle");
  a_busy_start: assert property ($rose(rdy_oe_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("busy began inside a frame");
  a_standby_idle: assert property (deselected |-> standby_o == !rdy_oe_o)
    else $error("standby wrong while deselected");
  a_busy_length: assert property ($fell(rdy_oe_o) && busy_len_q > 9'h008
    |-> busy_len_q == 9'(`DW_NV_CYC))
    else $error("access cycle length wrong");
  a_wiper_frame_end: assert property ($changed(wiper_o) |-> $past(cs_n_i, 2))
    else $error("wiper changed inside a frame");
  a_wiper_awake: assert property ($changed(wiper_o) && !$past(rdy_oe_o)
    && $past(resetn_i, 3) |-> $past(awake_o))
    else $error("wiper changed while asleep");
  a_mode_by_load: assert property ($changed({wiper_o[1].buffer_mode_bit,
    wiper_o[0].buffer_mode_bit}) && $past(resetn_i, 3) |-> rdy_oe_o || !awake_o)
    else $error("buffer mode changed without a load");
endmodule // dw_wiper_ctrl_chk

bind dw_wiper_ctrl dw_wiper_ctrl_chk dw_wiper_ctrl_chk_i (.clk_i, .resetn_i, .cs_n_i, .sclk_i,
  .sdo_oe_o, .rdy_oe_o, .standby_o, .awake_o, .wiper_o);

// file: dv/dw_wiper_ctrl_test.sv
`timescale 1ns/10ps
`include "dw_consts.svh"
module dw_wiper_ctrl_test
  import dw_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic cs_n_i, sclk_i, sdi_i, sdo_oe_o, rdy_oe_o, awake_o;
  logic sdo_o, rdy_o, standby_o;
  dw_wiper_t [1:0] wiper_o;
  logic [8:0] wip [2];
  logic [8:0] slot [2][4];
  logic [23:0] prev;
  logic [8:0] rd_val;
  logic [24:0] plan [$];
  bit awake, prev_ok, prev_rd;
  int failures, num_checks, cyc;

  always #2 clk_i = ~clk_i;

  dw_wiper_ctrl dw_wiper_ctrl_i (.clk_i, .resetn_i, .cs_n_i, .sclk_i, .sdi_i, .wp_n_i,
    .sdo_o, .sdo_oe_o, .rdy_o, .rdy_oe_o, .standby_o, .awake_o, .wiper_o);
  dw_host dw_host_i (.clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .rdy_i(rdy_o),
    .rdy_oe_i(rdy_oe_o), .cs_n_o(cs_n_i),
    .sclk_o(sclk_i), .sdi_o(sdi_i));

  task automatic tally_and_finish;
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", n, exp, seen);
      failures++;
    end
  endtask

  function automatic logic [24:0] f(input logic [3:0] op, input logic [3:0] a,
    input logic [8:0] d, input logic wp = 1'b1);
    return {wp, op, a, 7'h00, d};
  endfunction

  // send one frame, then compare with the reference model
  task automatic go(input logic [24:0] p);
    logic [23:0] c;
    logic [23:0] r;
    logic [3:0] op;
    logic [1:0] sl;
    logic ch;
    logic acc;
    logic flow;
    c = p[23:0];
    op = c[23:20];
    sl = c[19:18];
    ch = c[16];
    wp_n_i <= p[24];
    @(posedge clk_i);
    dw_host_i.frame(c, r);
    if (prev_ok)
      check("resp", r, prev_rd ? {prev[23:16], 7'h00, rd_val} : prev);
    acc = !c[17] && (awake || op == `DW_OP_WAKE);
    flow = acc && (op inside {`DW_OP_RDWIPER, `DW_OP_RDSLOT, `DW_OP_PROG, `DW_OP_SAVE,
      `DW_OP_LOAD, `DW_OP_ERASE});
    prev_rd = acc && (op inside {`DW_OP_RDWIPER, `DW_OP_RDSLOT});
    if (acc)
      case (op)
        `DW_OP_WAKE: awake = 1'b1;
        `DW_OP_SLEEP: awake = 1'b0;
        `DW_OP_RESET:
        begin
          wip[0] = slot[0][0];
          wip[1] = slot[1][0];
          awake = 1'b0;
        end
        `DW_OP_WRITE: wip[ch][7:0] = c[7:0];
        `DW_OP_UP: wip[ch] = wip[ch] + 9'(wip[ch][7:0] != 8'hFF);
        `DW_OP_DOWN: wip[ch] = wip[ch] - 9'(wip[ch][7:0] != 8'h00);
        `DW_OP_PROG: if (p[24]) slot[ch][sl] = c[8:0];
        `DW_OP_SAVE: if (p[24]) slot[ch][sl] = wip[ch];
        `DW_OP_ERASE: if (p[24]) slot[ch][sl] = `DW_SLOT_ERASED;
        `DW_OP_LOAD: wip[ch] = slot[ch][sl];
        `DW_OP_RDWIPER: rd_val = wip[ch];
        `DW_OP_RDSLOT: rd_val = slot[ch][sl];
        default: ;
      endcase
    prev = c;
    prev_ok = 1'b1;
    repeat (8) @(posedge clk_i);
    check("busy", 24'(rdy_oe_o), 24'(flow));
    dw_host_i.wait_ready();
    check("standby", 24'(standby_o), 24'h000001);
    check("awake", 24'(awake_o), 24'(awake));
    check("wiper", 24'(wiper_o), {6'h00, wip[1], wip[0]});
  endtask

  // hang guard, about two and a half times the expected run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(28718));
    wip = '{default: `DW_SLOT_DEFAULT};
    slot = '{default: `DW_SLOT_DEFAULT};
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("wiper", 24'(wiper_o), {6'h00, wip[1], wip[0]});
    plan = {f(`DW_OP_WRITE, 4'h0, 9'($urandom)), f(`DW_OP_WAKE, 4'h0, 9'h000),
      f(`DW_OP_WRITE, 4'h0, 9'h0FF), f(`DW_OP_UP, 4'h0, 9'h000),
      f(`DW_OP_WRITE, 4'h1, 9'h000), f(`DW_OP_DOWN, 4'h1, 9'h000),
      f(`DW_OP_UP, 4'h1, 9'h000), f(`DW_OP_PROG, 4'h9, {1'b1, 8'($urandom)}),
      f(`DW_OP_LOAD, 4'h9, 9'h000), f(`DW_OP_WRITE, 4'h1, 9'($urandom)),
      f(`DW_OP_SAVE, 4'hD, 9'h000), f(`DW_OP_RDSLOT, 4'hD, 9'h000),
      f(`DW_OP_RDWIPER, 4'h1, 9'h000), f(`DW_OP_PROG, 4'h4, 9'($urandom), 1'b0),
      f(`DW_OP_SAVE, 4'h4, 9'h000, 1'b0), f(`DW_OP_ERASE, 4'h4, 9'h000, 1'b0),
      f(`DW_OP_RDSLOT, 4'h4, 9'h000, 1'b0), f(`DW_OP_LOAD, 4'h4, 9'h000, 1'b0),
      f(`DW_OP_ERASE, 4'h9, 9'h000), f(`DW_OP_RDSLOT, 4'h9, 9'h000),
      f(`DW_OP_WRITE, 4'h2, 9'($urandom)), f(`DW_OP_SLEEP, 4'h0, 9'h000),
      f(`DW_OP_UP, 4'h0, 9'h000), f(`DW_OP_WAKE, 4'h0, 9'h000)};
    foreach (plan[i])
      go(plan[i]);
    // every slot of channel 0 written and read back
    for (int s = 0; s < 4; s++)
    begin
      go(f(`DW_OP_PROG, 4'(s * 4), 9'($urandom)));
      go(f(`DW_OP_RDSLOT, 4'(s * 4), 9'h000));
    end
    go(f(`DW_OP_RESET, 4'h0, 9'h000));
    go(f(`DW_OP_WAKE, 4'h0, 9'h000));
    go(f(`DW_OP_NOP, 4'h0, 9'h000));
    tally_and_finish();
  end
endmodule // dw_wiper_ctrl_test

// file: hw/dw_consts.svh
`ifndef DW_CONSTS_SVH
`define DW_CONSTS_SVH

// frame layout, most significant bit first
`define DW_FRAME_BITS 24
`define DW_CNT_W 5
`define DW_OP_HI 23
`define DW_OP_LO 20
`define DW_SLOT_HI 19
`define DW_SLOT_LO 18
`define DW_CHAN_HI 17
`define DW_CHAN_LO 16
`define DW_DATA_HI 8
`define DW_DATA_LO 0
`define DW_MODE_BIT 8

// opcode_bits encodings
`define DW_OP_NOP 4'h0
`define DW_OP_WAKE 4'h1
`define DW_OP_PROG 4'h2
`define DW_OP_SAVE 4'h3
`define DW_OP_WRITE 4'h4
`define DW_OP_UP 4'h7
`define DW_OP_SLEEP 4'h8
`define DW_OP_RESET 4'h9
`define DW_OP_RDSLOT 4'hA
`define DW_OP_LOAD 4'hB
`define DW_OP_RDWIPER 4'hC
`define DW_OP_ERASE 4'hD
`define DW_OP_DOWN 4'hF

// wiper range and saved word values
`define DW_POS_MIN 8'h00
`define DW_POS_MAX 8'hFF
`define DW_SLOT_DEFAULT 9'h080
`define DW_SLOT_ERASED 9'h1FF

// internal nonvolatile access cycle, least time
`define DW_CLK_MHZ 250
`define DW_NV_ACCESS_NS 1000
`define DW_NV_CYC ((`DW_NV_ACCESS_NS * `DW_CLK_MHZ + 999) / 1000)
`define DW_BUSY_W 9

`endif

// file: hw/dw_pkg.sv
`include "dw_consts.svh"

package dw_pkg;

  typedef enum logic [1:0] {
    DW_ST_INIT = 2'b00,
    DW_ST_IDLE = 2'b01,
    DW_ST_BUSY = 2'b10
  } dw_fsm_t;

  // one channel as seen by the analog side
  typedef struct packed {
    logic buffer_mode_bit;
    logic [7:0] wiper_position_reg;
  } dw_wiper_t;

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;
    logic sdi_meta;
    logic sdi_sync;
    logic wp_meta;
    logic wp_sync;
    dw_fsm_t st;
    logic armed;
    logic awake;
    logic [`DW_FRAME_BITS-1:0] rx;
    logic [`DW_CNT_W-1:0] cnt;
    logic [`DW_FRAME_BITS-1:0] tx;
    logic [`DW_FRAME_BITS-1:0] resp;
    logic resp_valid;
    logic [`DW_BUSY_W-1:0] busy_cnt;
    dw_wiper_t [1:0] chan;
    logic [1:0][3:0][8:0] saved_setting_store;
  } dw_state_t;

endpackage

// file: hw/dw_wiper_ctrl.sv
`timescale 1ns/10ps
`include "dw_consts.svh"

// What this block does
// - sample serial input on each rising serial clock edge while selected
// - first output bit at select fall, later bits on falling serial clock
// - select high releases output and enters standby unless access cycle runs
// - ignore everything until a select falling edge after power-up
// - ready/busy low acknowledges read, program, load and save commands
// - ready/busy released high when the access cycle ends, whether or not selected
// - nonvolatile access runs a timed cycle; commands refused until done
// - ready/busy valid for every command, high when no cycle runs
// - write guard low blocks nonvolatile changes; slot reads and loads allowed
// - each channel holds four 9-bit saved words, position plus buffer mode
// - power-up and software reset load each channel from slot 0
// - wiper register is 8 bits, 256 positions
// - buffer mode bit 0 off, 1 on, independent per channel
// - mode changes only via load or slot 0 recall; direct write keeps mode
// - up and down move one step and saturate at the ends
// - direct write replaces wiper register with host 8-bit value
// - program slot stores host 9-bit data into selected slot
// - save wiper copies wiper and mode into selected slot
// - two slot-select bits of the instruction byte pick the slot
// - load wiper copies selected slot into wiper and mode
// - 24-bit frame msb first: opcode, address, seven ignored, nine data
// - opcode table for read, write, program, load, save, step, power commands
// - channel select 00 picks channel 0, 01 channel 1, others unused
// - asleep after power-up, reset or sleep; only wake accepted
module dw_wiper_ctrl
  import dw_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic wp_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic rdy_o,
  output logic rdy_oe_o,
  output logic standby_o,
  output logic awake_o,
  output dw_wiper_t [1:0] wiper_o
);

  // whole block state, registered in one place
  dw_state_t q;
  dw_state_t d;

  // edge and select decode of the synced pins
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  logic frame_done;

  // edges are taken from the synchronised copies only
  assign cs_fall = q.cs_prev & ~q.cs_sync;
  assign cs_rise = ~q.cs_prev & q.cs_sync;
  assign sclk_rise = ~q.sclk_prev & q.sclk_sync;
  assign sclk_fall = q.sclk_prev & ~q.sclk_sync;
  assign selected = ~q.cs_sync;

  // short frames never execute, long ones run on their last 24 bits; arming needs a select fall first
  assign frame_done = cs_rise & q.armed & (q.cnt == `DW_CNT_W'(`DW_FRAME_BITS));

  always_comb
  begin
    // fields of the frame just received
    logic [3:0] op;
    logic [1:0] slot;
    logic [1:0] chan_sel;
    logic ch;
    logic chan_ok;
    logic [8:0] data;
    logic [8:0] stored;
    logic nv_go;
    op = q.rx[`DW_OP_HI:`DW_OP_LO];
    slot = q.rx[`DW_SLOT_HI:`DW_SLOT_LO];
    chan_sel = q.rx[`DW_CHAN_HI:`DW_CHAN_LO];
    ch = chan_sel[0];
    chan_ok = (chan_sel[1] == 1'b0);
    data = q.rx[`DW_DATA_HI:`DW_DATA_LO];
    stored = q.saved_setting_store[ch][slot];
    nv_go = 1'b0;

    // by default every field keeps its value
    d = q;

    // two flops per pin before any logic looks
    d.cs_meta = cs_n_i;
    d.cs_sync = q.cs_meta;
    d.cs_prev = q.cs_sync;

    // serial clock, edges found one flop later
    d.sclk_meta = sclk_i;
    d.sclk_sync = q.sclk_meta;
    d.sclk_prev = q.sclk_sync;
    // data and write guard, plain levels
    d.sdi_meta = sdi_i;
    d.sdi_sync = q.sdi_meta;
    d.wp_meta = wp_n_i;
    d.wp_sync = q.wp_meta;

    // frame start: arm, clear count, load first output bit
    if (cs_fall)
    begin
      d.armed = 1'b1;
      d.cnt = '0;
      // read result if one is pending, else the last frame for daisy chaining
      d.tx = q.resp_valid ? q.resp : q.rx;
      d.resp_valid = 1'b0;
    end

    // shift in on rising serial clock, msb first
    if (selected && sclk_rise && !cs_fall)
    begin
      d.rx = {q.rx[`DW_FRAME_BITS-2:0], q.sdi_sync};
      if (q.cnt != `DW_CNT_W'(`DW_FRAME_BITS))
      begin
        d.cnt = q.cnt + `DW_CNT_W'(1);
      end
    end

    // later output bits move on the falling serial clock
    if (selected && sclk_fall && !cs_fall)
    begin
      d.tx = {q.tx[`DW_FRAME_BITS-2:0], 1'b0};
    end

    // sequencer: power-up recall, idle decode, access cycle
    case (q.st)
      // recall slot 0; one cycle after power-up or software reset
      DW_ST_INIT:
      begin
        for (int i = 0; i < 2; i++)
        begin
          d.chan[i] = q.saved_setting_store[i][0];
        end
        d.st = DW_ST_IDLE;
      end

      // waiting for a complete frame
      DW_ST_IDLE:
      begin
        // short frames are dropped; long frames run on their last 24 bits
        if (frame_done)
        begin
          // asleep: nothing but wake is taken
          if (!q.awake)
          begin
            if (op == `DW_OP_WAKE)
            begin
              d.awake = 1'b1;
            end
          end
          else
          begin
            case (op)
              // power commands act on the whole device
              `DW_OP_WAKE: d.awake = 1'b1;
              `DW_OP_SLEEP: d.awake = 1'b0;
              // software reset: recall slot 0 and fall asleep
              `DW_OP_RESET:
              begin
                d.awake = 1'b0;
                d.st = DW_ST_INIT;
              end

              // direct position write
              `DW_OP_WRITE:
              begin
                if (chan_ok)
                begin
                  // mode bit left alone on a direct write
                  d.chan[ch].wiper_position_reg = data[7:0];
                end
              end

              // single steps, held at the ends rather than wrapping
              `DW_OP_UP:
              begin
                if (chan_ok && q.chan[ch].wiper_position_reg != `DW_POS_MAX)
                begin
                  d.chan[ch].wiper_position_reg =
                    q.chan[ch].wiper_position_reg + 8'h01;
                end
              end

              `DW_OP_DOWN:
              begin
                if (chan_ok && q.chan[ch].wiper_position_reg != `DW_POS_MIN)
                begin
                  d.chan[ch].wiper_position_reg =
                    q.chan[ch].wiper_position_reg - 8'h01;
                end
              end

              // reads answer in the next frame, with a busy cycle like the rest
              `DW_OP_RDWIPER:
              begin
                if (chan_ok)
                begin
                  // echo the instruction byte, then the wiper word
                  d.resp = {q.rx[`DW_OP_HI:`DW_CHAN_LO], 7'h00, q.chan[ch]};
                  d.resp_valid = 1'b1;
                  nv_go = 1'b1;
                end
              end

              `DW_OP_RDSLOT:
              begin
                if (chan_ok)
                begin
                  // echo the instruction byte, then the stored word
                  d.resp = {q.rx[`DW_OP_HI:`DW_CHAN_LO], 7'h00, stored};
                  d.resp_valid = 1'b1;
                  nv_go = 1'b1;
                end
              end

              // stores; the guard pin blocks the write but not the busy cycle
              `DW_OP_PROG:
              begin
                if (chan_ok)
                begin
                  if (q.wp_sync)
                  begin
                    d.saved_setting_store[ch][slot] = data;
                  end
                  nv_go = 1'b1;
                end
              end

              `DW_OP_SAVE:
              begin
                if (chan_ok)
                begin
                  if (q.wp_sync)
                  begin
                    d.saved_setting_store[ch][slot] = q.chan[ch];
                  end
                  nv_go = 1'b1;
                end
              end

              `DW_OP_ERASE:
              begin
                if (chan_ok)
                begin
                  if (q.wp_sync)
                  begin
                    d.saved_setting_store[ch][slot] = `DW_SLOT_ERASED;
                  end
                  nv_go = 1'b1;
                end
              end

              `DW_OP_LOAD:
              begin
                if (chan_ok)
                begin
                  // besides the slot 0 recall, the only path that changes the buffer mode
                  d.chan[ch] = stored;
                  nv_go = 1'b1;
                end
              end

              // nop and unused codes leave everything as it was
              default: d.awake = q.awake;
            endcase
          end
          // every nonvolatile access, read or write, holds off the next frame
          if (nv_go)
          begin
            d.busy_cnt = `DW_BUSY_W'(`DW_NV_CYC);
            d.st = DW_ST_BUSY;
          end
        end
      end

      // nonvolatile access cycle in progress
      DW_ST_BUSY:
      begin
        // frames arriving now are ignored; the host is meant to poll first
        d.busy_cnt = q.busy_cnt - `DW_BUSY_W'(1);
        if (q.busy_cnt == `DW_BUSY_W'(1))
        begin
          d.st = DW_ST_IDLE;
        end
      end

      // unreachable codes fall back to a fresh recall
      default: d.st = DW_ST_INIT;
    endcase
  end

  // single state register; saved words restart at their default
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.cs_meta <= 1'b1;
      q.cs_sync <= 1'b1;
      q.cs_prev <= 1'b1;
      q.wp_meta <= 1'b1;
      q.wp_sync <= 1'b1;
      q.st <= DW_ST_INIT;
      q.saved_setting_store <= {8{`DW_SLOT_DEFAULT}};
    end
    else
    begin
      // every field moves together
      q <= d;
    end
  end

  // open drain: only ever pull low
  assign sdo_o = 1'b0;
  // held off in the select-fall cycle, while tx still holds leftovers
  assign sdo_oe_o = selected & ~cs_fall & ~q.tx[`DW_FRAME_BITS-1];

  // ready/busy is open drain too
  assign rdy_o = 1'b0;
  // low while the access cycle or the slot 0 recall runs, so every command can be polled
  assign rdy_oe_o = (q.st != DW_ST_IDLE);
  // standby waits for a running access cycle to finish
  assign standby_o = q.cs_sync & (q.st == DW_ST_IDLE);
  assign awake_o = q.awake;

  // per-channel outputs to the analog ladder
  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    assign wiper_o[g] = q.chan[g];
  end

endmodule // dw_wiper_ctrl
